// ===== src/alfa_pkg.sv
// package: register map, field layout and mode codes of the audio link fifo access block
package alfa_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W    = 32;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned SMP_W     = 16;
  localparam int unsigned PTR_W     = 4;
  localparam int unsigned DEPTH     = 16;
  localparam int unsigned NCH       = 3;
  localparam int unsigned EVT_W     = 6;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PCM_PTR_ADDR   = 32'h5b000010;
  localparam logic [ADDR_W-1:0] MIC_PTR_ADDR   = 32'h5b000014;
  localparam logic [ADDR_W-1:0] PCM_DATA_ADDR  = 32'h5b000018;
  localparam logic [ADDR_W-1:0] MIC_DATA_ADDR  = 32'h5b00001c;
  localparam logic [ADDR_W-1:0] MODE_ADDR      = 32'h5b000020;
  localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR  = 32'h5b000024;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR  = 32'h5b000028;
  localparam logic [ADDR_W-1:0] FLAG_ADDR      = 32'h5b00002c;
  localparam logic [DATA_W-1:0] REG_RESET      = 32'h00000000;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned PCM_OUT_RD_LSB = 24;
  localparam int unsigned PCM_IN_RD_LSB  = 16;
  localparam int unsigned PCM_OUT_WR_LSB = 8;
  localparam int unsigned PCM_IN_WR_LSB  = 0;
  localparam int unsigned MIC_RD_LSB     = 16;
  localparam int unsigned MIC_WR_LSB     = 0;
  localparam int unsigned LEFT_LSB       = 16;
  localparam int unsigned RIGHT_LSB      = 0;
  localparam int unsigned MODE_OUT_LSB   = 12;
  localparam int unsigned MODE_IN_LSB    = 10;
  localparam int unsigned MODE_MIC_LSB   = 8;
  // event bits in status, mask and flag registers
  localparam int unsigned EV_OUT_UNDER   = 5;
  localparam int unsigned EV_IN_OVER     = 4;
  localparam int unsigned EV_MIC_OVER    = 3;
  localparam int unsigned EV_OUT_THR     = 2;
  localparam int unsigned EV_IN_THR      = 1;
  localparam int unsigned EV_MIC_THR     = 0;
  localparam int unsigned EV_LSB         = 16;

  // ---------------------------------------------------------------
  // transfer modes
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_PIO  = 2'h1;
  localparam logic [1:0] MODE_DMA  = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;

  // half level of a sixteen-entry fifo
  localparam logic [PTR_W:0] HALF_LVL = 5'h08;

  typedef enum logic [1:0] {
    ALFA_IDLE,
    ALFA_ACK
  } alfa_bus_st_t;

endpackage : alfa_pkg

// ===== src/alfa_fifo.sv
// sixteen-entry sample fifo with visible read and write pointers
`timescale 1ns/1ps

module alfa_fifo
  import alfa_pkg::*;
#(
  parameter int unsigned W = 32
)
(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // fill side
  input  wire logic                  push_i,
  input  wire logic [W-1:0]          wdata_i,
  // drain side
  input  wire logic                  pop_i,
  output logic      [W-1:0]          rdata_o,
  // state
  output logic      [PTR_W-1:0]      rd_ptr_o,
  output logic      [PTR_W-1:0]      wr_ptr_o,
  output logic                       empty_o,
  output logic                       full_o,
  output logic      [PTR_W:0]        level_o
);

  logic [W-1:0]     mem_ff [DEPTH];
  logic [PTR_W-1:0] rd_ff;
  logic [PTR_W-1:0] wr_ff;
  logic [PTR_W:0]   cnt_ff;
  wire              do_push;
  wire              do_pop;

  // refuse a push when full and a pop when empty so pointers never cross
  assign do_push  = push_i && !full_o;
  assign do_pop   = pop_i && !empty_o;
  assign empty_o  = (cnt_ff == '0);
  assign full_o   = (cnt_ff == HALF_LVL + HALF_LVL);
  assign rd_ptr_o = rd_ff;
  assign wr_ptr_o = wr_ff;
  assign level_o  = cnt_ff;
  assign rdata_o  = mem_ff[rd_ff];

  // sample storage, no reset needed on the array
  always_ff @(posedge clk_i)
  begin
    if (do_push)
      mem_ff[wr_ff] <= wdata_i;
  end

  // pointers wrap naturally from fifteen to zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_ff  <= '0;
      wr_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (do_push)
        wr_ff <= wr_ff + 1'b1;
      if (do_pop)
        rd_ff <= rd_ff + 1'b1;
      if (do_push && !do_pop)
        cnt_ff <= cnt_ff + 1'b1;
      else if (do_pop && !do_push)
        cnt_ff <= cnt_ff - 1'b1;
    end
  end

endmodule : alfa_fifo

// ===== src/alfa_irq.sv
// sticky event status with write-one-to-clear and masked interrupt
`timescale 1ns/1ps

module alfa_irq
  import alfa_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // events and software clear
  input  wire logic [EVT_W-1:0]      evt_i,
  input  wire logic                  clr_we_i,
  input  wire logic [EVT_W-1:0]      clr_i,
  input  wire logic [EVT_W-1:0]      mask_i,
  // state
  output logic      [EVT_W-1:0]      stat_o,
  output logic                       irq_o
);

  logic [EVT_W-1:0] stat_ff;
  wire  [EVT_W-1:0] clr_m;

  assign clr_m  = clr_we_i ? clr_i : '0;
  assign stat_o = stat_ff;
  assign irq_o  = |(stat_ff & mask_i);

  // a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      stat_ff <= '0;
    else
      stat_ff <= (stat_ff & ~clr_m) | evt_i;
  end

endmodule : alfa_irq

// ===== src/alfa_top.sv
// top: wishbone slave, three sample fifos, mode gating and flags
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps

// Behaviour
// - pcm pointers show playback read/write pointers
// - pcm pointers show capture pointers, rest zero
// - mic pointers show mic read pointer
// - mic pointers show mic write pointer
// - pcm data write pushes left/right playback
// - pcm data read pops left/right capture
// - mic data returns one mono sample
// - pcm pointers read only, reset zero
// - mic pointers read only, reset zero
// - transfer mode gates channel servicing
// - underrun when empty, overrun when full
// - threshold flags at half level
module alfa_top
  import alfa_pkg::*;
(
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // wishbone slave
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [alfa_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [alfa_pkg::DATA_W-1:0] wb_dat_i,
  output logic      [alfa_pkg::DATA_W-1:0] wb_dat_o,
  output logic                             wb_ack_o,
  // slot framer: playback drain
  input  wire logic                        out_pop_i,
  output logic      [alfa_pkg::DATA_W-1:0] out_data_o,
  output logic                             out_valid_o,
  // slot framer: capture fill
  input  wire logic                        in_push_i,
  input  wire logic [alfa_pkg::DATA_W-1:0] in_data_i,
  input  wire logic                        mic_push_i,
  input  wire logic [alfa_pkg::SMP_W-1:0]  mic_data_i,
  // dma requests
  output logic                             out_dma_req_o,
  output logic                             in_dma_req_o,
  output logic                             mic_dma_req_o,
  // interrupt
  output logic                             irq_o
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  // bus state, read data and control registers
  alfa_bus_st_t      st_ff;
  alfa_bus_st_t      nxt_st;
  logic [DATA_W-1:0] rdat_ff;
  logic [DATA_W-1:0] nxt_rdat;
  logic [5:0]        mode_ff;
  logic [EVT_W-1:0]  mask_ff;
  // fifo state seen from the top
  logic [PTR_W-1:0]  o_rd, o_wr, i_rd, i_wr, m_rd, m_wr;
  logic              o_empty, o_full, i_empty, i_full, m_empty, m_full;
  logic [PTR_W:0]    o_lvl, i_lvl, m_lvl;
  logic [DATA_W-1:0] o_q, i_q;
  logic [SMP_W-1:0]  m_q;
  logic [EVT_W-1:0]  stat;
  // decode, gating and flag wires
  wire               req;
  wire               wr_acc;
  wire               rd_acc;
  wire               sel_pptr, sel_mptr, sel_pdat, sel_mdat;
  wire               sel_mode, sel_stat, sel_mask, sel_flag;
  wire               wr_full;
  wire [1:0]         m_out, m_in, m_mic;
  wire               on_out, on_in, on_mic;
  wire               pio_out, pio_in, pio_mic;
  wire [EVT_W-1:0]   lvl_flag;
  wire [EVT_W-1:0]   evt;
  wire [DATA_W-1:0]  pptr_word, mptr_word, flag_word;
  wire               pdat_live;
  wire               mdat_live;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // register map, all full-word compares on the byte address:
  //   pcm_fifo_pointers   read only, four pointer nibbles
  //   mic_fifo_pointers   read only, two pointer nibbles
  //   pcm_fifo_data_port  write pushes playback, read pops capture
  //   mic_fifo_data_port  read pops one mono sample
  //   mode, irq status, irq mask and live flags follow
  // partial decode was traded away: aliases would let a stray
  // access pop a fifo entry that software never sees
  //
  // a request is taken only from idle so each access acts once;
  // a request standing in the ack cycle waits for idle
  assign req      = wb_cyc_i && wb_stb_i && (st_ff == ALFA_IDLE);
  assign wr_acc   = req && wb_we_i;
  assign rd_acc   = req && !wb_we_i;
  assign wr_full  = (wb_sel_i == 4'hf);
  assign sel_pptr = (wb_adr_i == PCM_PTR_ADDR);
  assign sel_mptr = (wb_adr_i == MIC_PTR_ADDR);
  assign sel_pdat = (wb_adr_i == PCM_DATA_ADDR);
  assign sel_mdat = (wb_adr_i == MIC_DATA_ADDR);
  assign sel_mode = (wb_adr_i == MODE_ADDR);
  assign sel_stat = (wb_adr_i == IRQ_STAT_ADDR);
  assign sel_mask = (wb_adr_i == IRQ_MASK_ADDR);
  assign sel_flag = (wb_adr_i == FLAG_ADDR);

  // ---------------------------------------------------------------
  // transfer mode gating
  // ---------------------------------------------------------------
  // six-bit mode field: playback, capture, microphone from the top
  // reserved code behaves as off: no servicing at all
  assign m_out   = mode_ff[5:4];
  assign m_in    = mode_ff[3:2];
  assign m_mic   = mode_ff[1:0];
  assign pio_out = (m_out == MODE_PIO);
  assign pio_in  = (m_in == MODE_PIO);
  assign pio_mic = (m_mic == MODE_PIO);
  assign on_out  = pio_out || (m_out == MODE_DMA);
  assign on_in   = pio_in || (m_in == MODE_DMA);
  assign on_mic  = pio_mic || (m_mic == MODE_DMA);

  // data ports answer only while their channel is serviced; a read in
  // off mode returns zero and leaves the entry in place
  assign pdat_live = on_in && !i_empty;
  assign mdat_live = on_mic && !m_empty;

  // ---------------------------------------------------------------
  // fifos
  // ---------------------------------------------------------------
  // each fifo refuses a push when full and a pop when empty, so the
  // pointers shown to software never cross
  // playback: bus pushes full word, left high half and right low half
  alfa_fifo #(.W(DATA_W)) u_out (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .push_i   (wr_acc && sel_pdat && wr_full && on_out),
    .wdata_i  (wb_dat_i),
    .pop_i    (out_pop_i && on_out),
    .rdata_o  (o_q),
    .rd_ptr_o (o_rd),
    .wr_ptr_o (o_wr),
    .empty_o  (o_empty),
    .full_o   (o_full),
    .level_o  (o_lvl)
  );

  // capture: framer pushes, bus read pops
  // a read of an empty capture fifo pops nothing and returns zero
  alfa_fifo #(.W(DATA_W)) u_in (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .push_i   (in_push_i && on_in),
    .wdata_i  (in_data_i),
    .pop_i    (rd_acc && sel_pdat && on_in),
    .rdata_o  (i_q),
    .rd_ptr_o (i_rd),
    .wr_ptr_o (i_wr),
    .empty_o  (i_empty),
    .full_o   (i_full),
    .level_o  (i_lvl)
  );

  // microphone: mono samples only
  // upper half of the mic data word is reserved and reads zero
  alfa_fifo #(.W(SMP_W)) u_mic (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .push_i   (mic_push_i && on_mic),
    .wdata_i  (mic_data_i),
    .pop_i    (rd_acc && sel_mdat && on_mic),
    .rdata_o  (m_q),
    .rd_ptr_o (m_rd),
    .wr_ptr_o (m_wr),
    .empty_o  (m_empty),
    .full_o   (m_full),
    .level_o  (m_lvl)
  );

  // ---------------------------------------------------------------
  // level flags and events
  // ---------------------------------------------------------------
  // flags only count while the channel is serviced, else an idle
  // playback fifo would raise underrun forever
  // thresholds use the live level, so a fifo that sits at half keeps
  // re-setting its status bit until software drains or fills it
  assign lvl_flag[EV_OUT_UNDER] = on_out && o_empty;
  assign lvl_flag[EV_IN_OVER]   = on_in && i_full;
  assign lvl_flag[EV_MIC_OVER]  = on_mic && m_full;
  assign lvl_flag[EV_OUT_THR]   = on_out && (o_lvl <= HALF_LVL);
  assign lvl_flag[EV_IN_THR]    = on_in && (i_lvl >= HALF_LVL);
  assign lvl_flag[EV_MIC_THR]   = on_mic && (m_lvl >= HALF_LVL);
  assign evt = lvl_flag;

  // sticky status: write one to clear, an event in the same cycle wins
  alfa_irq u_irq (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .evt_i    (evt),
    .clr_we_i (wr_acc && sel_stat),
    .clr_i    (wb_dat_i[EV_LSB +: EVT_W]),
    .mask_i   (mask_ff),
    .stat_o   (stat),
    .irq_o    (irq_o)
  );

  // dma requests follow threshold flags in dma mode
  // they are levels; the dma engine drops them by moving data
  assign out_dma_req_o = (m_out == MODE_DMA) && lvl_flag[EV_OUT_THR];
  assign in_dma_req_o  = (m_in == MODE_DMA) && lvl_flag[EV_IN_THR];
  assign mic_dma_req_o = (m_mic == MODE_DMA) && lvl_flag[EV_MIC_THR];
  assign out_valid_o   = on_out && !o_empty;
  assign out_data_o    = o_q;

  // ---------------------------------------------------------------
  // read data words
  // ---------------------------------------------------------------
  // reserved nibbles are tied to zero here, not in the mux
  assign pptr_word = {4'h0, o_rd, 4'h0, i_rd, 4'h0, o_wr, 4'h0, i_wr};
  assign mptr_word = {12'h000, m_rd, 12'h000, m_wr};
  assign flag_word = {10'h000, lvl_flag, 16'h0000};

  // read mux; pointer registers have no write path at all
  // unmapped reads fall through to zero and are still acked
  always_comb
  begin
    nxt_rdat = REG_RESET;
    if (rd_acc)
    begin
      if (sel_pptr)
        nxt_rdat = pptr_word;
      else if (sel_mptr)
        nxt_rdat = mptr_word;
      else if (sel_pdat)
        nxt_rdat = pdat_live ? i_q : REG_RESET;
      else if (sel_mdat)
        nxt_rdat = mdat_live ? {16'h0000, m_q} : REG_RESET;
      else if (sel_mode)
        nxt_rdat = {18'h00000, m_out, m_in, m_mic, 8'h00};
      else if (sel_stat)
        nxt_rdat = {10'h000, stat, 16'h0000};
      else if (sel_mask)
        nxt_rdat = {10'h000, mask_ff, 16'h0000};
      else if (sel_flag)
        nxt_rdat = flag_word;
    end
  end

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  // every access, mapped or not, gets ack one cycle after it is taken
  // one wait state keeps decode and the read mux off the ack path
  always_comb
  begin
    nxt_st = st_ff;
    unique case (st_ff)
      ALFA_IDLE: if (req) nxt_st = ALFA_ACK;
      ALFA_ACK:  nxt_st = ALFA_IDLE;
      default:   nxt_st = ALFA_IDLE;
    endcase
  end

  // ack straight from the state flop, read data from its own flop
  assign wb_ack_o = (st_ff == ALFA_ACK);
  assign wb_dat_o = rdat_ff;

  // read data register clears itself outside the ack cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_ff   <= ALFA_IDLE;
      rdat_ff <= REG_RESET;
    end
    else
    begin
      st_ff   <= nxt_st;
      rdat_ff <= nxt_rdat;
    end
  end

  // control registers, byte lanes 1 and 2 hold the fields
  // lane 1 carries the mode field, lane 2 the mask; a write with
  // the wrong lane enables leaves the field untouched
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_ff <= '0;
      mask_ff <= '0;
    end
    else if (wr_acc)
    begin
      if (sel_mode && wb_sel_i[1])
        mode_ff <= wb_dat_i[MODE_MIC_LSB +: 6];
      if (sel_mask && wb_sel_i[2])
        mask_ff <= wb_dat_i[EV_LSB +: EVT_W];
    end
  end

endmodule : alfa_top

// ===== verification/alfa_checker.sv
// checker: bus timing and reserved fields of the fifo access block
`timescale 1ns/1ps

module alfa_checker
  import alfa_pkg::*;
(
  // clock and reset
  input wire logic                        clk_i,
  input wire logic                        rst_i,
  // bus
  input wire logic                        wb_cyc_i,
  input wire logic                        wb_stb_i,
  input wire logic                        wb_we_i,
  input wire logic [alfa_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [alfa_pkg::DATA_W-1:0] wb_dat_o,
  input wire logic                        wb_ack_o,
  // status outputs
  input wire logic                        out_valid_o,
  input wire logic                        out_dma_req_o,
  input wire logic                        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // a read answer; address is still held by the master at the ack edge
  wire rd_ack = wb_ack_o && !wb_we_i;
  wire known  = wb_adr_i inside {PCM_PTR_ADDR, MIC_PTR_ADDR, PCM_DATA_ADDR, MIC_DATA_ADDR,
                                 MODE_ADDR, IRQ_STAT_ADDR, IRQ_MASK_ADDR, FLAG_ADDR};

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack did not follow the request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  pcm_rsvd_a: assert property (rd_ack && wb_adr_i == PCM_PTR_ADDR |-> (wb_dat_o & 32'hf0f0f0f0) == 32'h0)
    else $error("pcm pointer reserved bits set");
  mic_rsvd_a: assert property (rd_ack && wb_adr_i == MIC_PTR_ADDR |-> (wb_dat_o & 32'hfff0fff0) == 32'h0)
    else $error("mic pointer reserved bits set");
  mic_data_a: assert property (rd_ack && wb_adr_i == MIC_DATA_ADDR |-> (wb_dat_o & 32'hffff0000) == 32'h0)
    else $error("mic data upper half set");
  unmapped_zero_a: assert property (rd_ack && !known |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  reset_quiet_a: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_o && !out_valid_o && !out_dma_req_o)
    else $error("outputs active after reset");

  cover property (rd_ack && wb_adr_i == PCM_DATA_ADDR);
  cover property (irq_o);
  cover property (out_dma_req_o);
endmodule : alfa_checker

bind alfa_top alfa_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .out_valid_o(out_valid_o), .out_dma_req_o(out_dma_req_o), .irq_o(irq_o));

// ===== verification/alfa_framer.sv
// partner: slot framer model that drains playback and fills capture fifos
`timescale 1ns/1ps

module alfa_framer
  import alfa_pkg::*;
(
  // clock
  input  wire logic                        clk_i,
  // playback drain
  input  wire logic [alfa_pkg::DATA_W-1:0] out_data_i,
  input  wire logic                        out_valid_i,
  output logic                             out_pop_o,
  // capture fill
  output logic                             in_push_o,
  output logic      [alfa_pkg::DATA_W-1:0] in_data_o,
  output logic                             mic_push_o,
  output logic      [alfa_pkg::SMP_W-1:0]  mic_data_o
);
  initial
  begin
    out_pop_o  = 1'b0;
    in_push_o  = 1'b0;
    mic_push_o = 1'b0;
    in_data_o  = 32'h0;
    mic_data_o = 16'h0;
  end

  // pop only what is offered; left sample rides in the upper half
  task automatic pop(output logic [31:0] w, output logic ok);
    @(posedge clk_i);
    ok = out_valid_i;
    w  = out_data_i;
    out_pop_o <= ok;
    @(posedge clk_i);
    out_pop_o <= 1'b0;
  endtask : pop

  // released data lines flip so a stale word is never mistaken for fresh
  task automatic cap(input logic [31:0] w);
    @(posedge clk_i);
    in_push_o <= 1'b1;
    in_data_o <= w;
    @(posedge clk_i);
    in_push_o <= 1'b0;
    in_data_o <= ~w;
  endtask : cap

  task automatic mic(input logic [15:0] s);
    @(posedge clk_i);
    mic_push_o <= 1'b1;
    mic_data_o <= s;
    @(posedge clk_i);
    mic_push_o <= 1'b0;
    mic_data_o <= ~s;
  endtask : mic
endmodule : alfa_framer

// ===== verification/audio_link_fifo_access_bench.sv
// testbench: register access, fifo traffic, flags and interrupt
`timescale 1ns/1ps

module audio_link_fifo_access_bench;
  import alfa_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [31:0] adr = 32'h0, dat = 32'h0, q;
  logic [3:0]  sel = 4'h0;
  logic ok;
  wire  [31:0] rdat, out_data, in_data;
  wire  [15:0] mic_data;
  wire  ack, out_pop, out_valid, in_push, mic_push, out_dma, in_dma, mic_dma, irq;
  int   num_errors = 0, n_compared = 0;

  always #2 clk_i = ~clk_i;

  alfa_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .out_pop_i(out_pop),
    .out_data_o(out_data), .out_valid_o(out_valid), .in_push_i(in_push), .in_data_i(in_data),
    .mic_push_i(mic_push), .mic_data_i(mic_data), .out_dma_req_o(out_dma), .in_dma_req_o(in_dma),
    .mic_dma_req_o(mic_dma), .irq_o(irq));
  alfa_framer frm (.clk_i(clk_i), .out_data_i(out_data), .out_valid_i(out_valid), .out_pop_o(out_pop),
    .in_push_o(in_push), .in_data_o(in_data), .mic_push_o(mic_push), .mic_data_o(mic_data));

  // ---------------------------------------------------------------
  // bus cycles and comparisons
  // ---------------------------------------------------------------
  function automatic logic [31:0] smp(input int i);
    return {16'h1000 + i[15:0], 16'h2000 + i[15:0]};
  endfunction : smp

  // request held until the ack edge; one idle cycle follows
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, a, d, 4'hf};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask : xfer

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    cmp(nm, e, q);
  endtask : rd

  // levels are looked at mid-cycle, once the edge's updates have landed
  task automatic lv(input string nm, input logic e, input logic g);
    @(negedge clk_i);
    cmp(nm, {31'h0, e}, {31'h0, g});
  endtask : lv

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // watchdog: whole run is well under a few thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    stop_test();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("pcm_ptr", PCM_PTR_ADDR, 32'h0);
    rd("mic_ptr", MIC_PTR_ADDR, 32'h0);
    xfer(1'b1, PCM_PTR_ADDR, 32'hffffffff);
    xfer(1'b1, MIC_PTR_ADDR, 32'hffffffff);
    xfer(1'b1, PCM_DATA_ADDR, smp(9));
    rd("pcm_ptr", PCM_PTR_ADDR, 32'h0);
    rd("mic_ptr", MIC_PTR_ADDR, 32'h0);
    rd("unmapped", 32'h5b000030, 32'h0);
    $display("test reset done");
    xfer(1'b1, MODE_ADDR, 32'h00001500);
    for (int i = 0; i < 3; i++) xfer(1'b1, PCM_DATA_ADDR, smp(i));
    rd("pcm_ptr", PCM_PTR_ADDR, 32'h00000300);
    frm.pop(q, ok);
    cmp("out_word", smp(0), q);
    rd("pcm_ptr", PCM_PTR_ADDR, 32'h01000300);
    frm.cap(smp(100));
    frm.cap(smp(101));
    frm.mic(16'h3c3c);
    rd("pcm_ptr", PCM_PTR_ADDR, 32'h01000302);
    rd("mic_ptr", MIC_PTR_ADDR, 32'h00000001);
    rd("pcm_data", PCM_DATA_ADDR, smp(100));
    rd("mic_data", MIC_DATA_ADDR, 32'h00003c3c);
    rd("mic_ptr", MIC_PTR_ADDR, 32'h00010001);
    $display("test pio done");
    // fill past full: only fourteen of twenty fit behind the two queued
    for (int i = 3; i < 23; i++) xfer(1'b1, PCM_DATA_ADDR, smp(i));
    for (int i = 1; i <= 16; i++)
    begin
      frm.pop(q, ok);
      cmp("out_word", smp(i), q);
    end
    frm.pop(q, ok);
    lv("out_empty", 1'b0, ok);
    rd("pcm_ptr", PCM_PTR_ADDR, 32'h01010102);
    rd("flags", FLAG_ADDR, 32'h00240000);
    rd("status", IRQ_STAT_ADDR, 32'h00240000);
    lv("irq", 1'b0, irq);
    xfer(1'b1, IRQ_MASK_ADDR, 32'h00200000);
    lv("irq", 1'b1, irq);
    xfer(1'b1, MODE_ADDR, 32'h00000500);
    xfer(1'b1, IRQ_STAT_ADDR, 32'h00240000);
    lv("irq", 1'b0, irq);
    rd("status", IRQ_STAT_ADDR, 32'h0);
    $display("test wrap and irq done");
    for (int i = 0; i < 16; i++) frm.cap(smp(200 + i));
    rd("flags", FLAG_ADDR, 32'h00120000);
    rd("pcm_ptr", PCM_PTR_ADDR, 32'h01010101);
    rd("pcm_data", PCM_DATA_ADDR, smp(101));
    xfer(1'b1, MODE_ADDR, 32'h00002500);
    lv("out_dma", 1'b1, out_dma);
    lv("in_dma", 1'b0, in_dma);
    lv("mic_dma", 1'b0, mic_dma);
    xfer(1'b1, MODE_ADDR, 32'h00003500);
    lv("out_dma", 1'b0, out_dma);
    lv("out_valid", 1'b0, out_valid);
    $display("test overrun and modes done");
    xfer(1'b1, MODE_ADDR, 32'h00002a00);
    for (int i = 0; i < 17; i++) frm.mic(16'h4000 + i[15:0]);
    lv("in_dma", 1'b1, in_dma);
    lv("mic_dma", 1'b1, mic_dma);
    rd("flags", FLAG_ADDR, 32'h002f0000);
    rd("status", IRQ_STAT_ADDR, 32'h003f0000);
    xfer(1'b1, IRQ_STAT_ADDR, 32'h00100000);
    rd("status", IRQ_STAT_ADDR, 32'h002f0000);
    xfer(1'b1, MODE_ADDR, 32'h00000000);
    rd("pcm_data", PCM_DATA_ADDR, 32'h0);
    rd("mic_data", MIC_DATA_ADDR, 32'h0);
    rd("pcm_ptr", PCM_PTR_ADDR, 32'h01020101);
    rd("mic_ptr", MIC_PTR_ADDR, 32'h00010001);
    $display("test dma and gating done");
    stop_test();
  end
endmodule : audio_link_fifo_access_bench
